/* File: logic/rcsr_ctl_status.sv */
// Purpose: mode, flag, validity and rate registers of the real-time clock
// Assumes: time counters, alarm bytes and divider taps live outside, on clk_sys
// Notes: counters act on time_advance / dst_load in the cycle they are high
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns

// Functional notes
// - spring: 1:59:59 jumps to 3:00:00
// - fall: 1:59:59 back to 1:00:00
// - mode bit 1 selects 24 or 12 hour
// - mode bit 2 selects binary or BCD
// - mode bit 3 always reads zero
// - bit 4 enables update-ended interrupt
// - bit 5 enables alarm interrupt after update
// - bit 6 enables periodic interrupt, rate select
// - reset clears enables, keeps other mode bits
// - set mode freezes user-visible time
// - update sets flag bit 4
// - alarm match sets flag bit 5
// - selected tap transition sets flag bit 6
// - flag read or reset clears flags
// - summary flag when enable and flag both
// - interrupt output low exactly when summary set
// - validity bit 7, other bits zero
// - validity read sets validity bit
// - registers at indices 0Ah to 0Dh
// - update pending reads zero in set mode
// - alarm byte with bits 7,6 set matches all
module rcsr_ctl_status
	import rcsr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic por_b,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic time_tick,
	input wire logic [15:0] div_taps,
	input wire logic update_pending,
	input wire logic [7:0] cur_sec,
	input wire logic [7:0] cur_min,
	input wire logic [7:0] cur_hour,
	input wire logic [7:0] cur_dow,
	input wire logic [7:0] cur_date,
	input wire logic [7:0] cur_month,
	input wire logic [7:0] alm_sec,
	input wire logic [7:0] alm_min,
	input wire logic [7:0] alm_hour,
	input wire logic batt_low,
	output logic irq_out_n,
	output logic time_advance,
	output logic dst_load,
	output logic [7:0] dst_hour,
	output logic hour_24,
	output logic binary_data_select,
	output logic set_mode,
	output logic [3:0] periodic_rate_sel,
	output logic [2:0] div_ctl
);
	rcsr_state_t st;
	rcsr_state_t next_st;

	// encode a small value as the counters hold it
	function automatic logic [7:0] rcsr_enc(input logic [6:0] v,
		input logic bin);
		logic [6:0] tens;
		logic [6:0] ones;
		tens = v / 7'h0a;
		ones = v % 7'h0a;
		if (bin)
			return {1'b0, v};
		return {tens[3:0], ones[3:0]};
	endfunction : rcsr_enc

	// alarm byte compare with wildcard
	function automatic logic rcsr_amatch(input logic [7:0] alm,
		input logic [7:0] cur);
		return (alm[7:6] == RCSR_WILDCARD) || (alm == cur);
	endfunction : rcsr_amatch

	logic last_second;
	logic is_sunday;
	logic spring_day;
	logic fall_day;
	logic spring_hit;
	logic fall_hit;
	logic advance_now;
	logic alarm_hit;
	logic tap_now;
	logic tap_evt;
	logic [2:0] evt;
	logic [2:0] flag_after;
	logic wr_rate;
	logic wr_mode;
	logic rd_flag;
	logic rd_valid;

	always_comb begin
		// time is stepped only when set mode is off
		advance_now = time_tick && !st.set_mode;
		last_second = (cur_sec == rcsr_enc(RCSR_LAST_SEC,
			st.binary_data_select))
			&& (cur_min == rcsr_enc(RCSR_LAST_SEC,
			st.binary_data_select))
			&& (cur_hour == RCSR_HOUR_ONE);
		is_sunday = (cur_dow == RCSR_SUNDAY);
		spring_day = (cur_month == rcsr_enc(RCSR_APRIL,
			st.binary_data_select))
			&& (cur_date <= rcsr_enc(RCSR_FIRST_WEEK_END,
			st.binary_data_select));
		fall_day = (cur_month == rcsr_enc(RCSR_OCTOBER,
			st.binary_data_select))
			&& (cur_date >= rcsr_enc(RCSR_LAST_WEEK_START,
			st.binary_data_select));
		spring_hit = st.daylight_saving_enable && advance_now
			&& last_second && is_sunday && spring_day;
		// the repeated hour must not fall back a second time
		fall_hit = st.daylight_saving_enable && advance_now
			&& last_second && is_sunday && fall_day
			&& !st.fall_done;
		alarm_hit = st.alarm_chk && rcsr_amatch(alm_sec, cur_sec)
			&& rcsr_amatch(alm_min, cur_min)
			&& rcsr_amatch(alm_hour, cur_hour);
		tap_now = div_taps[st.periodic_rate_sel];
		// rate zero means no periodic events
		tap_evt = (st.periodic_rate_sel != 4'h0)
			&& (tap_now != st.tap_prev);
		evt = {tap_evt, alarm_hit, st.advance};
		wr_rate = wr && (addr == RCSR_ADDR_RATE);
		wr_mode = wr && (addr == RCSR_ADDR_MODE);
		rd_flag = rd && (addr == RCSR_ADDR_FLAG);
		rd_valid = rd && (addr == RCSR_ADDR_VALID);
	end

	always_comb begin
		next_st = st;
		next_st.batt_s1 = batt_low;
		next_st.batt_s2 = st.batt_s1;
		next_st.tap_prev = tap_now;
		next_st.advance = advance_now;
		next_st.alarm_chk = st.advance;
		next_st.dst_load = spring_hit || fall_hit;
		next_st.dst_hour = spring_hit ? RCSR_HOUR_THREE
			: RCSR_HOUR_ONE;
		if (fall_hit)
			next_st.fall_done = 1'b1;
		else if (advance_now && cur_hour == RCSR_HOUR_TWO)
			next_st.fall_done = 1'b0;

		if (wr_rate) begin
			next_st.periodic_rate_sel = wdata[RCSR_RATE_LSB +: 4];
			next_st.div_ctl = wdata[RCSR_DIV_LSB +: 3];
		end
		if (wr_mode) begin
			next_st.daylight_saving_enable = wdata[RCSR_DSE_BIT];
			next_st.hour_24 = wdata[RCSR_H24_BIT];
			next_st.binary_data_select = wdata[RCSR_BIN_BIT];
			next_st.irq_enable = wdata[RCSR_IE_LSB +: 3];
			next_st.set_mode = wdata[RCSR_SET_BIT];
		end

		// clear at the read's conclusion, a fresh event still wins
		flag_after = rd_flag ? 3'h0 : st.irq_flag;
		next_st.irq_flag = flag_after | evt;

		// battery low beats a validity read in the same cycle
		if (st.batt_s2)
			next_st.contents_valid = 1'b0;
		else if (rd_valid)
			next_st.contents_valid = 1'b1;

		if (!rst_b) begin
			next_st.irq_enable = 3'h0;
			next_st.irq_flag = 3'h0;
			next_st.advance = 1'b0;
			next_st.alarm_chk = 1'b0;
			next_st.dst_load = 1'b0;
		end
		next_st.irq_out_n = ~|(next_st.irq_enable
			& next_st.irq_flag);

		next_st.rdata = 8'h00;
		if (rd) begin
			case (addr)
				RCSR_ADDR_RATE: begin
					next_st.rdata[RCSR_RATE_LSB +: 4] = st.periodic_rate_sel;
					next_st.rdata[RCSR_DIV_LSB +: 3] = st.div_ctl;
					next_st.rdata[RCSR_PEND_BIT] = update_pending
						&& !st.set_mode;
				end
				RCSR_ADDR_MODE: begin
					next_st.rdata[RCSR_DSE_BIT] = st.daylight_saving_enable;
					next_st.rdata[RCSR_H24_BIT] = st.hour_24;
					next_st.rdata[RCSR_BIN_BIT] = st.binary_data_select;
					next_st.rdata[RCSR_SQW_BIT] = 1'b0;
					next_st.rdata[RCSR_IE_LSB +: 3] = st.irq_enable;
					next_st.rdata[RCSR_SET_BIT] = st.set_mode;
				end
				RCSR_ADDR_FLAG: begin
					next_st.rdata[RCSR_FLAG_LSB +: 3] = st.irq_flag;
					next_st.rdata[RCSR_IRQ_SUMMARY_FLAG_BIT] = !st.irq_out_n;
				end
				RCSR_ADDR_VALID: begin
					next_st.rdata[RCSR_VALID_BIT] = st.contents_valid;
				end
				default: begin
					next_st.rdata = 8'h00;
				end
			endcase
		end
	end

	// por_b sets everything; rst_b touches enables, flags and the advance, alarm-check and dst_load stages
	always_ff @(posedge clk_sys) begin
		if (!por_b)
			st <= RCSR_POR_STATE;
		else
			st <= next_st;
	end

	assign rdata = st.rdata;
	assign irq_out_n = st.irq_out_n;
	assign time_advance = st.advance;
	assign dst_load = st.dst_load;
	assign dst_hour = st.dst_hour;
	assign hour_24 = st.hour_24;
	assign binary_data_select = st.binary_data_select;
	assign set_mode = st.set_mode;
	assign periodic_rate_sel = st.periodic_rate_sel;
	assign div_ctl = st.div_ctl;

	chk_irq_follows_flags: assert property (
		@(posedge clk_sys) disable iff (!por_b)
		irq_out_n == !(|(st.irq_enable & st.irq_flag)))
		else $error("interrupt output does not follow summary");

	chk_flag_read_clear: assert property (
		@(posedge clk_sys) disable iff (!por_b || !rst_b)
		rd_flag && evt == 3'h0 ##1 rst_b |-> st.irq_flag == 3'h0)
		else $error("flags not cleared by flag read");

	chk_flag_event_wins: assert property (
		@(posedge clk_sys) disable iff (!por_b || !rst_b)
		time_advance ##1 rst_b |-> st.irq_flag[0])
		else $error("update flag missing after time update");

	chk_mode_bit3_zero: assert property (
		@(posedge clk_sys) disable iff (!por_b)
		rd && addr == RCSR_ADDR_MODE |=> rdata[RCSR_SQW_BIT] == 1'b0)
		else $error("mode bit 3 read as one");

	chk_valid_read_set: assert property (
		@(posedge clk_sys) disable iff (!por_b)
		rd_valid && !st.batt_s2 |=> st.contents_valid)
		else $error("validity not set after validity read");

	chk_enable_reset: assert property (
		@(posedge clk_sys) disable iff (!por_b)
		!rst_b && !wr_mode ##1 por_b |-> st.irq_enable == 3'h0
			&& $stable(st.hour_24) && $stable(st.set_mode))
		else $error("reset mishandled mode bits");

	chk_set_freezes: assert property (
		@(posedge clk_sys) disable iff (!por_b || !rst_b)
		set_mode && $stable(set_mode) |-> !time_advance)
		else $error("time advanced in set mode");

	chk_pending_set: assert property (
		@(posedge clk_sys) disable iff (!por_b)
		rd && addr == RCSR_ADDR_RATE && st.set_mode
			|=> !rdata[RCSR_PEND_BIT])
		else $error("update pending read one in set mode");

	chk_dst_disabled: assert property (
		@(posedge clk_sys) disable iff (!por_b || !rst_b)
		!st.daylight_saving_enable && !$past(wr_mode)
			|-> ##1 !dst_load)
		else $error("daylight step while disabled");

	chk_read_one_cycle: assert property (
		@(posedge clk_sys) disable iff (!por_b)
		!rd |=> rdata == 8'h00)
		else $error("read data outside the read cycle");

	chk_alarm_after_upd: assert property (
		@(posedge clk_sys) disable iff (!por_b || !rst_b)
		alarm_hit |-> $past(st.advance) ##1 st.irq_flag[1])
		else $error("alarm flag timing wrong");

	chk_spring_step: assert property (
		@(posedge clk_sys) disable iff (!por_b || !rst_b)
		spring_hit && rst_b |=> dst_load && time_advance
			&& dst_hour == RCSR_HOUR_THREE)
		else $error("spring step not loaded");

	chk_fall_step: assert property (
		@(posedge clk_sys) disable iff (!por_b || !rst_b)
		fall_hit && rst_b |=> dst_load && time_advance
			&& dst_hour == RCSR_HOUR_ONE)
		else $error("fall step not loaded");

	chk_reset_irq_off: assert property (
		@(posedge clk_sys) disable iff (!por_b)
		!rst_b |=> irq_out_n && st.irq_enable == 3'h0
			&& st.irq_flag == 3'h0)
		else $error("reset left interrupt state");

	chk_flag_low_zero: assert property (
		@(posedge clk_sys) disable iff (!por_b)
		rd_flag |=> rdata[3:0] == 4'h0)
		else $error("flag low bits read as one");

	chk_irq_summary_flag_mirror: assert property (
		@(posedge clk_sys) disable iff (!por_b)
		rd_flag |=> rdata[RCSR_IRQ_SUMMARY_FLAG_BIT] != $past(irq_out_n))
		else $error("summary flag differs from output");

	chk_valid_low_zero: assert property (
		@(posedge clk_sys) disable iff (!por_b)
		rd_valid |=> rdata[6:0] == 7'h00)
		else $error("validity low bits read as one");

	chk_batt_clears: assert property (
		@(posedge clk_sys) disable iff (!por_b)
		st.batt_s2 |=> !st.contents_valid)
		else $error("validity kept while battery low");

	chk_periodic_flag: assert property (
		@(posedge clk_sys) disable iff (!por_b || !rst_b)
		tap_evt && rst_b |=> st.irq_flag[2])
		else $error("periodic flag missing after tap change");

	chk_update_irq: assert property (
		@(posedge clk_sys) disable iff (!por_b || !rst_b)
		time_advance && st.irq_enable[0] && !wr_mode && rst_b
			|=> !irq_out_n)
		else $error("update interrupt not raised");

	chk_alarm_irq: assert property (
		@(posedge clk_sys) disable iff (!por_b || !rst_b)
		alarm_hit && st.irq_enable[1] && !wr_mode && rst_b
			|=> !irq_out_n)
		else $error("alarm interrupt not raised");

	chk_periodic_irq: assert property (
		@(posedge clk_sys) disable iff (!por_b || !rst_b)
		tap_evt && st.irq_enable[2] && !wr_mode && rst_b
			|=> !irq_out_n)
		else $error("periodic interrupt not raised");

	chk_mode_write: assert property (
		@(posedge clk_sys) disable iff (!por_b)
		wr_mode |=> hour_24 == $past(wdata[RCSR_H24_BIT])
			&& binary_data_select == $past(wdata[RCSR_BIN_BIT])
			&& set_mode == $past(wdata[RCSR_SET_BIT]))
		else $error("mode write not taken");

	chk_rate_write: assert property (
		@(posedge clk_sys) disable iff (!por_b)
		wr_rate |=> periodic_rate_sel
			== $past(wdata[RCSR_RATE_LSB +: 4]))
		else $error("rate write not taken");

	chk_wildcard_match: assert property (
		@(posedge clk_sys) disable iff (!por_b)
		st.alarm_chk && alm_sec[7:6] == RCSR_WILDCARD
			&& alm_min[7:6] == RCSR_WILDCARD
			&& alm_hour[7:6] == RCSR_WILDCARD |-> alarm_hit)
		else $error("wildcard alarm did not match");

	chk_unmapped_zero: assert property (
		@(posedge clk_sys) disable iff (!por_b)
		rd && (addr < RCSR_ADDR_RATE || addr > RCSR_ADDR_VALID)
			|=> rdata == 8'h00)
		else $error("unmapped address read non-zero");

	chk_tick_steps: assert property (
		@(posedge clk_sys) disable iff (!por_b || !rst_b)
		time_tick && !st.set_mode && rst_b |=> time_advance)
		else $error("tick did not step time");
endmodule : rcsr_ctl_status

/* File: logic/rcsr_pkg.sv */
// Purpose: constants and state type for the clock control/status registers
// Assumes: 8-bit register port, register index used directly as address
// Notes: power-on values apply only on por_b; rst_b is the partial reset
package rcsr_pkg;
	// register addresses (register index)
	localparam logic [7:0] RCSR_ADDR_RATE = 8'h0a;
	localparam logic [7:0] RCSR_ADDR_MODE = 8'h0b;
	localparam logic [7:0] RCSR_ADDR_FLAG = 8'h0c;
	localparam logic [7:0] RCSR_ADDR_VALID = 8'h0d;

	// rate register fields
	localparam int RCSR_RATE_LSB = 0;
	localparam int RCSR_DIV_LSB = 4;
	localparam int RCSR_PEND_BIT = 7;

	// mode register fields
	localparam int RCSR_DSE_BIT = 0;
	localparam int RCSR_H24_BIT = 1;
	localparam int RCSR_BIN_BIT = 2;
	localparam int RCSR_SQW_BIT = 3;
	localparam int RCSR_IE_LSB = 4;
	localparam int RCSR_SET_BIT = 7;

	// flag and validity register fields; event index 0 update, 1 alarm, 2 periodic
	localparam int RCSR_FLAG_LSB = 4;
	localparam int RCSR_IRQ_SUMMARY_FLAG_BIT = 7;
	localparam int RCSR_VALID_BIT = 7;

	// daylight saving calendar points and hour values, alarm wildcard
	localparam logic [6:0] RCSR_APRIL = 7'h04;
	localparam logic [6:0] RCSR_OCTOBER = 7'h0a;
	localparam logic [6:0] RCSR_FIRST_WEEK_END = 7'h07;
	localparam logic [6:0] RCSR_LAST_WEEK_START = 7'h19;
	localparam logic [6:0] RCSR_LAST_SEC = 7'h3b;
	localparam logic [7:0] RCSR_SUNDAY = 8'h01;
	localparam logic [7:0] RCSR_HOUR_ONE = 8'h01;
	localparam logic [7:0] RCSR_HOUR_TWO = 8'h02;
	localparam logic [7:0] RCSR_HOUR_THREE = 8'h03;
	localparam logic [1:0] RCSR_WILDCARD = 2'h3;

	typedef struct packed {
		logic [3:0] periodic_rate_sel;
		logic [2:0] div_ctl;
		logic daylight_saving_enable;
		logic hour_24;
		logic binary_data_select;
		logic set_mode;
		logic [2:0] irq_enable;
		logic [2:0] irq_flag;
		logic contents_valid;
		logic batt_s1;
		logic batt_s2;
		logic tap_prev;
		logic advance;
		logic alarm_chk;
		logic dst_load;
		logic [7:0] dst_hour;
		logic fall_done;
		logic irq_out_n;
		logic [7:0] rdata;
	} rcsr_state_t;

	localparam rcsr_state_t RCSR_POR_STATE = '{
		periodic_rate_sel: 4'h0, div_ctl: 3'h0,
		daylight_saving_enable: 1'b0, hour_24: 1'b0,
		binary_data_select: 1'b0, set_mode: 1'b0,
		irq_enable: 3'h0, irq_flag: 3'h0, contents_valid: 1'b0,
		batt_s1: 1'b0, batt_s2: 1'b0, tap_prev: 1'b0,
		advance: 1'b0, alarm_chk: 1'b0, dst_load: 1'b0,
		dst_hour: 8'h00, fall_done: 1'b0, irq_out_n: 1'b1,
		rdata: 8'h00};
endpackage : rcsr_pkg

/* File: verif/rcsr_host.sv */
// Purpose: host-side bus master for the clock control registers
// Assumes: one access at a time, strobes one cycle long
// Notes: tasks start and end just after a rising edge
`timescale 1ns/1ns
module rcsr_host (
	input wire logic clk_sys,
	output logic [7:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [7:0] rdata
);
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	task automatic write(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		wdata <= ~d;
		@(posedge clk_sys);
	endtask : write

	// data stands only in the cycle after the strobe
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 d = rdata;
		@(posedge clk_sys);
	endtask : read
endmodule : rcsr_host

/* File: verif/tb_rcsr_ctl_status.sv */
// Purpose: self-checking bench for the clock control/status registers
// Assumes: counters and divider are modelled by bench-driven levels
// Notes: BCD values except in the binary-mode daylight case; dow 1 is Sunday
`timescale 1ns/1ns
module tb_rcsr_ctl_status
	import rcsr_pkg::*;
;
	logic clk_sys = 0, rst_b = 0, por_b = 0, time_tick = 0;
	logic update_pending = 0, batt_low = 0;
	logic [15:0] div_taps = 16'h0000;
	logic [7:0] sec = 0, mn = 0, hr = 0, dow = 0, dt = 0, mon = 0;
	logic [7:0] asec = 8'h30, amin = 8'h30, ahr = 8'h30, d;
	logic adv, ld;
	logic [7:0] hl;
	wire [7:0] addr, wdata, rdata, dst_hour;
	wire wr, rd, irq_out_n, time_advance, dst_load;
	wire h24, bdm, setm;
	wire [3:0] prs;
	wire [2:0] dvc;
	int n_errors = 0, tests_run = 0, cyc = 0;

	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			summarize();
		end
	end

	rcsr_host host (.clk_sys(clk_sys), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata));
	rcsr_ctl_status dut (.clk_sys(clk_sys), .rst_b(rst_b), .por_b(por_b),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.time_tick(time_tick), .div_taps(div_taps),
		.update_pending(update_pending), .cur_sec(sec), .cur_min(mn),
		.cur_hour(hr), .cur_dow(dow), .cur_date(dt), .cur_month(mon),
		.alm_sec(asec), .alm_min(amin), .alm_hour(ahr),
		.batt_low(batt_low), .irq_out_n(irq_out_n),
		.time_advance(time_advance), .dst_load(dst_load),
		.dst_hour(dst_hour), .hour_24(h24), .binary_data_select(bdm),
		.set_mode(setm), .periodic_rate_sel(prs), .div_ctl(dvc));

	task automatic chk(input string n, input logic [7:0] e, s);
		tests_run++;
		if (s !== e) begin
			$display("BAD %s expected %h seen %h", n, e, s);
			n_errors++;
		end
	endtask : chk

	// one-second tick; catch the counter step it causes
	task automatic tick();
		time_tick <= 1'b1;
		@(posedge clk_sys);
		time_tick <= 1'b0;
		adv = 0;
		repeat (4) begin
			@(negedge clk_sys);
			if (time_advance === 1'b1) begin
				adv = 1;
				ld = dst_load;
				hl = dst_hour;
			end
		end
		@(posedge clk_sys);
	endtask : tick

	task automatic t_mode();
		host.write(RCSR_ADDR_MODE, 8'hff);
		chk("mode pins", 8'h07, {5'h0, setm, bdm, h24});
		host.read(RCSR_ADDR_MODE, d);
		chk("mode", 8'hf7, d);
		update_pending <= 1'b1;
		host.read(RCSR_ADDR_RATE, d);
		chk("rate", 8'h00, d);
		update_pending <= 1'b0;
		host.read(8'h0e, d);
		chk("unmapped", 8'h00, d);
		tick();
		chk("frozen", 8'h00, {7'h0, adv});
		rst_b <= 1'b0;
		@(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		host.read(RCSR_ADDR_MODE, d);
		chk("mode rst", 8'h87, d);
		chk("mode keep", 8'h07, {5'h0, setm, bdm, h24});
	endtask : t_mode

	task automatic t_update();
		host.write(RCSR_ADDR_MODE, 8'h10);
		tick();
		chk("adv", 8'h01, {7'h0, adv});
		chk("irq", 8'h00, {7'h0, irq_out_n});
		host.read(RCSR_ADDR_FLAG, d);
		chk("flag upd", 8'h90, d);
		host.read(RCSR_ADDR_FLAG, d);
		chk("flag clr", 8'h00, d);
		chk("irq off", 8'h01, {7'h0, irq_out_n});
		host.write(RCSR_ADDR_MODE, 8'h00);
		tick();
		host.read(RCSR_ADDR_FLAG, d);
		chk("flag noen", 8'h10, d);
	endtask : t_update

	task automatic t_alarm();
		{asec, amin, ahr} <= {3{8'hc0}};
		host.write(RCSR_ADDR_MODE, 8'h20);
		tick();
		chk("irq alm", 8'h00, {7'h0, irq_out_n});
		host.read(RCSR_ADDR_FLAG, d);
		chk("flag alm", 8'hb0, d);
		{asec, amin, ahr} <= {3{8'h30}};
	endtask : t_alarm

	task automatic t_periodic();
		host.write(RCSR_ADDR_RATE, 8'ha1);
		chk("rate pins", 8'h21, {1'b0, dvc, prs});
		update_pending <= 1'b1;
		host.read(RCSR_ADDR_RATE, d);
		chk("rate rd", 8'ha1, d);
		update_pending <= 1'b0;
		host.write(RCSR_ADDR_MODE, 8'h40);
		div_taps <= 16'h0002;
		repeat (3) @(posedge clk_sys);
		host.read(RCSR_ADDR_FLAG, d);
		chk("flag per", 8'hc0, d);
		div_taps <= 16'h0000;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b0;
		@(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		host.read(RCSR_ADDR_FLAG, d);
		chk("flag rst", 8'h00, d);
	endtask : t_periodic

	task automatic t_valid();
		host.read(RCSR_ADDR_VALID, d);
		chk("valid por", 8'h00, d);
		host.read(RCSR_ADDR_VALID, d);
		chk("valid set", 8'h80, d);
		batt_low <= 1'b1;
		repeat (4) @(posedge clk_sys);
		batt_low <= 1'b0;
		repeat (4) @(posedge clk_sys);
		host.read(RCSR_ADDR_VALID, d);
		chk("valid lo", 8'h00, d);
		host.read(RCSR_ADDR_VALID, d);
		chk("valid", 8'h80, d);
	endtask : t_valid

	task automatic t_dst(input logic [7:0] m, mo, da, input logic el,
		input logic [7:0] eh);
		logic [7:0] ls;
		// 59 as the counters hold it in the chosen data mode
		ls = m[RCSR_BIN_BIT] ? 8'h3b : 8'h59;
		host.write(RCSR_ADDR_MODE, m);
		{mon, dt, dow, hr, mn, sec} <= {mo, da, 8'h01, 8'h01, ls, ls};
		tick();
		chk("dst load", {7'h0, el}, {7'h0, adv & ld});
		if (el)
			chk("dst hour", eh, hl);
	endtask : t_dst

	task automatic summarize();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	initial begin
		repeat (5) @(posedge clk_sys);
		por_b <= 1'b1;
		rst_b <= 1'b1;
		@(posedge clk_sys);
		t_mode();
		t_update();
		t_alarm();
		t_periodic();
		t_valid();
		t_dst(8'h01, 8'h04, 8'h01, 1'b1, 8'h03);
		t_dst(8'h05, 8'h04, 8'h01, 1'b1, 8'h03);
		t_dst(8'h01, 8'h10, 8'h25, 1'b1, 8'h01);
		t_dst(8'h01, 8'h10, 8'h25, 1'b0, 8'h00);
		t_dst(8'h00, 8'h04, 8'h01, 1'b0, 8'h00);
		summarize();
	end
endmodule : tb_rcsr_ctl_status
